// ---- src/dcaf_cfg.svh ----
// Purpose: constants for the two-channel converter serial frame
// Assumes: link clock sampled by the 40 MHz system clock
// Notes:   frame counts are serial-clock falling edges within a frame; DCAF_ACQ_CYC and DCAF_PD_WAKE_CYC are system clock cycles
`ifndef DCAF_CFG_SVH
`define DCAF_CFG_SVH
`define DCAF_RES_BITS       14
`define DCAF_SHORT_FRAME    16
`define DCAF_LONG_FRAME     32
`define DCAF_LAST_SHORT     29
`define DCAF_LONG_DETECT    30
`define DCAF_CLK_MHZ        40
`define DCAF_SCLK_DIV       4
`define DCAF_PD_WAKE_NS     1000
`define DCAF_PD_WAKE_CYC    ((`DCAF_PD_WAKE_NS * `DCAF_CLK_MHZ + 999) / 1000)
`define DCAF_ACQ_CYC        8
`endif

// ---- src/dcaf_pkg.sv ----
// Purpose: shared types for the serial frame ends
// Assumes: nothing
// Notes:   coding selects the result format of the variant
package dcaf_pkg;
    typedef enum logic [0:0] {
        DCAF_CODE_BINARY = 1'b0,
        DCAF_CODE_TWOS   = 1'b1
    } dcaf_coding_e;
    typedef enum logic [1:0] {
        DCAF_H_IDLE  = 2'b00,
        DCAF_H_FRAME = 2'b01,
        DCAF_H_GAP   = 2'b10
    } dcaf_host_st_e;
endpackage : dcaf_pkg

// ---- src/dcaf_link_if.sv ----
// Purpose: serial link between converter end and host end
// Assumes: data pin is three-state, resolved here
// Notes:   data_line reads 1 when undriven (weak pull-up)
`timescale 1ns/1ps
interface dcaf_link_if;
    logic cs_n;
    logic sclk;
    logic channel_choice_pin;
    logic power_down_request_pin;
    logic sdo_o;
    logic sdo_oe;
    logic data_line;
    assign data_line = sdo_oe ? sdo_o : 1'b1;
    modport conv (input cs_n, input sclk, input channel_choice_pin, input power_down_request_pin,
                  output sdo_o, output sdo_oe);
    modport host (output cs_n, output sclk, output channel_choice_pin, output power_down_request_pin,
                  input data_line);
endinterface : dcaf_link_if

// ---- src/dcaf_conv.sv ----
// Purpose: converter end of the serial frame: sampling, conversion, data shift
// Assumes: link pins are asynchronous and pass two flip-flops
// Notes:   analog value is a digital input word per channel
// Summary of operation
// R01 - support 16 and 32 clock frames
// R02 - sample input at chip select fall
// R03 - short frame: acquire from 16th fall
// R04 - chip select fall drives MSB out
// R05 - later bits shift on falling edges
// R06 - short frame outputs previous frame result
// R07 - conversion completes at 16th falling edge
// R08 - raise between 16th and 29th keeps short; code clears long mode only for a raise after 16 to 28 falls, not after 29
// R09 - data output idle while select high
// R10 - host may stop clock after 16th
// R11 - channel pin low picks 0, high 1
// R12 - host holds channel until first rise
// R13 - host sets channel between rises one, two
// R14 - differential variant: two's complement result
// R15 - single-ended variant: straight binary result
// R16 - host prefers fast clock, long gaps
// R17 - 30th edge low: long mode, zeros next
// R18 - early rise aborts, next output invalid
// R19 - power-down requested at select rise
// R20 - host waits wake time after power-down
// R21 - 14 bits first, then zeros, in window
`timescale 1ns/1ps
`include "dcaf_cfg.svh"
module dcaf_conv #(
    parameter int                    RES     = `DCAF_RES_BITS,
    parameter dcaf_pkg::dcaf_coding_e CODING = dcaf_pkg::DCAF_CODE_BINARY
) (
    // system
    input  wire logic           clock,
    input  wire logic           resetn,
    // link
    dcaf_link_if.conv           link,
    // analog stand-in, offset-binary magnitude per channel
    input  wire logic [RES-1:0] analog_ch0,
    input  wire logic [RES-1:0] analog_ch1,
    // status
    output logic                long_mode,
    output logic                powered_down,
    output logic                result_invalid
);
    logic [1:0]     cs_s_q;
    logic [1:0]     sck_s_q;
    logic [1:0]     ch_s_q;
    logic [1:0]     pd_s_q;
    logic           cs_q;
    logic           sck_q;
    logic           cs_fall;
    logic           cs_rise;
    logic           sck_fall;
    logic           sck_rise;
    logic [5:0]     fall_cnt_q;
    logic           seen_rise_q;
    logic [RES-1:0] sample_q;
    logic [RES-1:0] result_q;
    logic           result_ok_q;
    logic           long_q;
    logic           zero_next_q;
    logic [15:0]    shift_q;
    logic           oe_q;
    logic           pd_q;
    logic           aborted_q;
    logic           acq_q;
    logic [RES-1:0] picked;
    logic [RES-1:0] coded;

    // link pins pass two flip-flops, a third stage finds the select and clock edges
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
        begin
            cs_s_q  <= 2'h3;
            sck_s_q <= 2'h0;
            ch_s_q  <= 2'h0;
            pd_s_q  <= 2'h0;
            cs_q    <= 1'b1;
            sck_q   <= 1'b0;
        end
        else
        begin
            cs_s_q  <= {cs_s_q[0], link.cs_n};
            sck_s_q <= {sck_s_q[0], link.sclk};
            ch_s_q  <= {ch_s_q[0], link.channel_choice_pin};
            pd_s_q  <= {pd_s_q[0], link.power_down_request_pin};
            cs_q    <= cs_s_q[1];
            sck_q   <= sck_s_q[1];
        end

    assign cs_fall  = cs_q & ~cs_s_q[1];
    assign cs_rise  = ~cs_q & cs_s_q[1];
    assign sck_fall = sck_q & ~sck_s_q[1] & ~cs_s_q[1];
    assign sck_rise = ~sck_q & sck_s_q[1] & ~cs_s_q[1];

    assign picked = ch_s_q[1] ? analog_ch1 : analog_ch0; // R11
    // differential: flip MSB of offset-binary to get two's complement
    assign coded  = (CODING == dcaf_pkg::DCAF_CODE_TWOS) ? (picked ^ {1'b1, {(RES-1){1'b0}}}) // R14
                                                         : picked; // R15

    // falling-edge count in the frame
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            fall_cnt_q <= 6'h00;
        else if (cs_fall)
            fall_cnt_q <= 6'h00;
        else if (sck_fall && fall_cnt_q != 6'h3F)
            fall_cnt_q <= fall_cnt_q + 6'h01;

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            seen_rise_q <= 1'b0;
        else if (cs_fall)
            seen_rise_q <= 1'b0;
        else if (sck_rise)
            seen_rise_q <= 1'b1;

    // sample held from select fall; acquisition otherwise tracks input
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            sample_q <= '0;
        else if (cs_fall)
            sample_q <= coded; // R02

    // conversion result lands at the 16th falling edge
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
        begin
            result_q    <= '0;
            result_ok_q <= 1'b0;
        end
        else if (sck_fall && fall_cnt_q == 6'(`DCAF_SHORT_FRAME - 1))
        begin
            result_q    <= sample_q; // R07
            result_ok_q <= 1'b1;
        end
        else if (cs_rise && fall_cnt_q < 6'(`DCAF_SHORT_FRAME))
            result_ok_q <= 1'b0; // R18

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            aborted_q <= 1'b0;
        else if (cs_rise)
            aborted_q <= fall_cnt_q < 6'(`DCAF_SHORT_FRAME); // R18

    // frame mode detection
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
        begin
            long_q      <= 1'b0;
            zero_next_q <= 1'b0;
        end
        else if (sck_fall && fall_cnt_q == 6'(`DCAF_LONG_DETECT - 1))
        begin
            long_q      <= 1'b1; // R17
            zero_next_q <= 1'b1;
        end
        else if (cs_rise && fall_cnt_q >= 6'(`DCAF_SHORT_FRAME) && fall_cnt_q < 6'(`DCAF_LAST_SHORT))
            long_q      <= 1'b0; // R08
        else if (cs_fall)
            zero_next_q <= 1'b0;

    // shift register: 14 bits msb first, then zero fill
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            shift_q <= 16'h0000;
        else if (cs_fall)
        begin
            if (zero_next_q)
                shift_q <= 16'h0000; // R17
            else
                shift_q <= {result_q, {(16-RES){1'b0}}}; // R06 R21
        end
        // a frame held past 16 falls goes on with the fresh result, no latency
        else if (sck_fall && fall_cnt_q == 6'(`DCAF_SHORT_FRAME - 1))
            shift_q <= {sample_q, {(16-RES){1'b0}}}; // R01
        else if (sck_fall && seen_rise_q)
            shift_q <= {shift_q[14:0], 1'b0}; // R05

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            oe_q <= 1'b0;
        else
            oe_q <= ~cs_s_q[1]; // R04 R09

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            pd_q <= 1'b0;
        else if (cs_rise)
            pd_q <= pd_s_q[1]; // R19

    // acquisition from the 16th fall, or from select rise, until the next select fall
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            acq_q <= 1'b1;
        else if (cs_fall)
            acq_q <= 1'b0; // R02
        else if (cs_rise || (sck_fall && fall_cnt_q == 6'(`DCAF_SHORT_FRAME - 1)))
            acq_q <= 1'b1; // R03

    // acquisition restarts after the 16th edge; power-down after conversion
    assign link.sdo_o    = shift_q[15]; // R04
    assign link.sdo_oe   = oe_q; // R09
    assign long_mode      = long_q;
    assign powered_down   = pd_q & acq_q; // R03 R19
    assign result_invalid = aborted_q | ~result_ok_q;
endmodule : dcaf_conv

// ---- src/dcaf_host.sv ----
// Purpose: host end: drives select, serial clock, channel, collects results
// Assumes: data line sampled through two flip-flops
// Notes:   serial clock made by divider from the system clock
`timescale 1ns/1ps
`include "dcaf_cfg.svh"
module dcaf_host #(
    parameter int GAP_CYC = `DCAF_ACQ_CYC
) (
    // system
    input  wire logic        clock,
    input  wire logic        resetn,
    // link
    dcaf_link_if.host        link,
    // request
    input  wire logic        start,
    input  wire logic        long_frame,
    input  wire logic        channel,
    input  wire logic        power_down,
    output logic             busy,
    // answer
    output logic [15:0]      rx_word,
    output logic             rx_valid
);
    dcaf_pkg::dcaf_host_st_e st_q;
    logic [1:0]              dl_s_q;
    logic [1:0]              div_q;
    logic                    sck_q;
    logic [5:0]              edges_q;
    logic [5:0]              frame_len_q;
    logic [15:0]             rx_q;
    logic [15:0]             word_q;
    logic                    vld_q;
    logic                    ch_q;
    logic                    pd_q;
    logic [7:0]              gap_q;
    logic                    tick;

    assign tick = div_q == 2'(`DCAF_SCLK_DIV / 2 - 1);

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            dl_s_q <= 2'h3;
        else
            dl_s_q <= {dl_s_q[0], link.data_line};

    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
        begin
            st_q        <= dcaf_pkg::DCAF_H_IDLE;
            div_q       <= 2'h0;
            sck_q       <= 1'b0;
            edges_q     <= 6'h00;
            frame_len_q <= 6'h00;
            rx_q        <= 16'h0000;
            word_q      <= 16'h0000;
            vld_q       <= 1'b0;
            ch_q        <= 1'b0;
            pd_q        <= 1'b0;
            gap_q       <= 8'h00;
        end
        else
        begin
            vld_q <= 1'b0;
            unique case (st_q)
                dcaf_pkg::DCAF_H_IDLE:
                begin
                    if (start)
                    begin
                        st_q        <= dcaf_pkg::DCAF_H_FRAME;
                        frame_len_q <= long_frame ? 6'(`DCAF_LONG_FRAME) : 6'(`DCAF_SHORT_FRAME); // R01
                        pd_q        <= power_down;
                        edges_q     <= 6'h00;
                        div_q       <= 2'h0;
                        sck_q       <= 1'b0;
                    end
                end
                dcaf_pkg::DCAF_H_FRAME:
                begin
                    div_q <= tick ? 2'h0 : div_q + 2'h1;
                    if (tick)
                    begin
                        if (!sck_q && edges_q == 6'h00)
                            ch_q <= channel; // R12 R13
                        if (sck_q)
                        begin
                            sck_q   <= 1'b0;
                            edges_q <= edges_q + 6'h01;
                        end
                        else
                        begin
                            // the bit of each fall returns through both synchronisers by the rise slot after the next fall
                            if (edges_q != 6'h00)
                                rx_q <= {rx_q[14:0], dl_s_q[1]};
                            if (edges_q == frame_len_q)
                            begin
                                // select rises one slot after the last fall, so the converter sees that fall
                                st_q   <= dcaf_pkg::DCAF_H_GAP; // R08 R10
                                word_q <= {rx_q[14:0], dl_s_q[1]};
                                vld_q  <= 1'b1;
                                gap_q  <= pd_q ? 8'(`DCAF_PD_WAKE_CYC + GAP_CYC) : 8'(GAP_CYC); // R20
                            end
                            else
                                sck_q <= 1'b1;
                        end
                    end
                end
                dcaf_pkg::DCAF_H_GAP:
                begin
                    if (gap_q != 8'h00)
                        gap_q <= gap_q - 8'h01; // R16
                    else
                        st_q <= dcaf_pkg::DCAF_H_IDLE;
                end
                default:
                    st_q <= dcaf_pkg::DCAF_H_IDLE;
            endcase
        end

    assign link.cs_n                   = st_q != dcaf_pkg::DCAF_H_FRAME;
    assign link.sclk                   = sck_q;
    assign link.channel_choice_pin     = ch_q;
    assign link.power_down_request_pin = pd_q;
    assign busy                        = st_q != dcaf_pkg::DCAF_H_IDLE;
    assign rx_word                     = word_q;
    assign rx_valid                    = vld_q;
endmodule : dcaf_host

// ---- tb/dcaf_link_checker.sv ----
// Purpose: wire checks of the serial frame link
// Assumes: host makes the serial clock from the system clock
// Notes:   fall_cnt_q counts serial clock falls in a frame
`timescale 1ns/1ps
module dcaf_link_checker (
    // system
    input wire logic clock,
    input wire logic resetn,
    // link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic channel_choice_pin,
    input wire logic power_down_request_pin,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic data_line
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [5:0] fall_cnt_q;
    logic [7:0] high_cnt_q;
    logic       pd_q;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn) fall_cnt_q <= 6'h00;
        else if (cs_n) fall_cnt_q <= 6'h00;
        else if ($fell(sclk)) fall_cnt_q <= fall_cnt_q + 6'h01;
    end
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn) high_cnt_q <= 8'hFF;
        else if (!cs_n) high_cnt_q <= 8'h00;
        else if (high_cnt_q != 8'hFF) high_cnt_q <= high_cnt_q + 8'h01;
    end
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn) pd_q <= 1'b0;
        else if ($rose(cs_n)) pd_q <= power_down_request_pin;
    end
    property p_idle_hiz; cs_n [*5] |-> !sdo_oe; endproperty
    a_idle_hiz: assert property (p_idle_hiz) else $error("data driven while deselected");
    property p_oe_on; $fell(cs_n) |-> ##[1:5] sdo_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("data not driven after select");
    property p_oe_hold; !cs_n [*5] |-> sdo_oe; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("data released inside frame");
    property p_sclk_still; cs_n && $past(cs_n) |-> !sclk; endproperty
    a_sclk_still: assert property (p_sclk_still) else $error("serial clock runs between frames");
    property p_len; $rose(cs_n) |-> fall_cnt_q == 6'h10 || fall_cnt_q == 6'h20; endproperty
    a_len: assert property (p_len) else $error("frame length not 16 or 32");
    property p_tail_zero;
        $fell(sclk) && !cs_n && fall_cnt_q[3:1] == 3'h7 |-> !data_line;
    endproperty
    a_tail_zero: assert property (p_tail_zero) else $error("fill bit not zero");
    property p_chan; $fell(cs_n) |-> $stable(channel_choice_pin) [*2]; endproperty
    a_chan: assert property (p_chan) else $error("channel moved at sampling");
    property p_shift_on_fall;
        $changed(sdo_o) && sdo_oe && $past(sdo_oe) |-> $past(sclk, 4) && !$past(sclk, 3);
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall) else $error("data bit moved off a clock fall");
    property p_gap; $fell(cs_n) |-> high_cnt_q >= (pd_q ? 8'h30 : 8'h08); endproperty
    a_gap: assert property (p_gap) else $error("select high time too short");
    c_short: cover property ($rose(cs_n) && fall_cnt_q == 6'h10);
    c_long: cover property ($rose(cs_n) && fall_cnt_q == 6'h20);
    c_pd: cover property ($rose(cs_n) && power_down_request_pin);
endmodule : dcaf_link_checker

// ---- tb/dcaf_serial_frame_test.sv ----
// Purpose: both ends joined, results checked against a frame model
// Assumes: host returns one 16 bit word per frame
// Notes:   channel pin set in a frame picks the next sample
`timescale 1ns/1ps
module dcaf_serial_frame_test;
    logic        clock;
    logic        resetn;
    logic        start;
    logic        long_frame;
    logic        channel;
    logic        power_down;
    logic        busy;
    logic        rx_valid;
    logic        long_mode;
    logic        powered_down;
    logic        result_invalid;
    logic [15:0] rx_word;
    logic [13:0] analog_ch0;
    logic [13:0] analog_ch1;
    logic [31:0] seed;
    int          bad_count = 0;
    int          check_count = 0;
    dcaf_link_if link ();
    dcaf_conv dcaf_conv_i (.clock(clock), .resetn(resetn), .link(link), .analog_ch0(analog_ch0),
        .analog_ch1(analog_ch1), .long_mode(long_mode), .powered_down(powered_down),
        .result_invalid(result_invalid));
    dcaf_host dcaf_host_i (.clock(clock), .resetn(resetn), .link(link), .start(start), .long_frame(long_frame),
        .channel(channel), .power_down(power_down), .busy(busy), .rx_word(rx_word), .rx_valid(rx_valid));
    dcaf_link_checker dcaf_link_checker_i (.clock(clock), .resetn(resetn), .cs_n(link.cs_n), .sclk(link.sclk),
        .channel_choice_pin(link.channel_choice_pin), .power_down_request_pin(link.power_down_request_pin),
        .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .data_line(link.data_line));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        conclude();
    end
    initial
    begin : main
        logic [13:0] prev;
        logic [13:0] cur;
        logic        pch;
        logic        zero_next;
        int          n;
        resetn = 1'b0;
        start = 1'b0;
        long_frame = 1'b0;
        channel = 1'b0;
        power_down = 1'b0;
        analog_ch0 = 14'h0000;
        analog_ch1 = 14'h0000;
        seed = 32'h956CEFC5;
        pch = 1'b0;
        zero_next = 1'b0;
        prev = 14'h0000;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            seed = xs(seed);
            analog_ch0 = seed[13:0];
            analog_ch1 = seed[27:14];
            channel = seed[28];
            long_frame = seed[30:29] == 2'h0 || i == 5 || i == 6;
            power_down = seed[3:0] == 4'h0 || i == 8;
            cur = pch ? analog_ch1 : analog_ch0;
            start = 1'b1;
            @(negedge clock);
            start = 1'b0;
            n = 0;
            while (rx_valid !== 1'b1 && n < 400)
            begin
                @(negedge clock);
                n++;
            end
            if (n == 400)
                bad_count++;
            if (i > 1)
                chk_word(rx_word, long_frame ? {cur, 2'h0} : zero_next ? 16'h0000 : {prev, 2'h0});
            zero_next = long_frame;
            prev = cur;
            pch = channel;
            n = 0;
            while (busy !== 1'b0 && n < 400)
            begin
                @(negedge clock);
                n++;
            end
            if (n == 400)
                bad_count++;
            chk_bit(long_mode, long_frame);
            chk_bit(powered_down, power_down);
            chk_bit(result_invalid, 1'b0);
        end
        conclude();
    end
endmodule : dcaf_serial_frame_test
